//--- verilog/pbsp_consts.svh
/*
  Constants of the probe and boundary-scan port: instruction codes,
  widths and the TMS reset count.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef PBSP_CONSTS_SVH
`define PBSP_CONSTS_SVH
`define PBSP_IR_W         3
`define PBSP_IR_EXTEST    3'h0
`define PBSP_IR_SAMPLE    3'h1
`define PBSP_IR_IDCODE    3'h6
`define PBSP_IR_BYPASS    3'h7
`define PBSP_ID_W         32
`define PBSP_ID_DEFAULT   32'h00000001
`define PBSP_TMS_RST_TCKS 5
`define PBSP_SEL_W        8
`endif

//--- verilog/pbsp_pkg.sv
/*
  Types of the probe and boundary-scan port.
  Assumes the constants header is on the include path.
*/
`include "pbsp_consts.svh"
package pbsp_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SDRS, CDR, SDR, E1DR, PDR, E2DR, UDR,
    SIRS, CIR, SIR, E1IR, PIR, E2IR, UIR
  } pbsp_tap_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } pbsp_jtag_in_t;

  typedef struct packed {
    logic clk;
    logic din;
  } pbsp_probe_in_t;
endpackage : pbsp_pkg

//--- verilog/pbsp_port.sv
/*
  Probe path and boundary-scan test access port of the device.
  Assumes the mode, probe and test pin inputs are asynchronous to clk_i and are synchronised
  here; the test clock is sampled and its edges found on clk_i.
*/
`include "pbsp_consts.svh"
// Operation
// - Probing is enabled only while the mode pin is high.
// - Controller shifts selection serially; device decodes it.
// - Each selected net is routed to probe output a or b.
// - Programmed security fuses make probing unavailable.
// - With probe reservation, probe pins are probe outputs, else user I/O.
// - Probing needs no change to user logic and no extra resources.
// - Reserved TDI and TMS tolerate floating or tie high.
// - Reserved TDO is a scan output that may float or chain onward.
// - Unreserved test pins act as ordinary user I/O.
// - No test reset pin; power-on reset clears the scan logic.
// - TMS pulled high internally keeps the controller in reset.
// - Five test clocks with TMS high reach the reset state.
// - Logic follows the standard access port with fixed instructions.
module pbsp_port #(
  parameter int NETS = 1 << `PBSP_SEL_W
) (
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   mode_i,
  input  wire pbsp_pkg::pbsp_probe_in_t probe_i,
  output logic                        probe_serial_out_o,
  input  wire logic                   fuse_secure_i,
  input  wire logic                   probe_reserve_i,
  input  wire logic [NETS-1:0]        nets_i,
  input  wire logic [1:0]             user_pr_i,
  output logic                        probe_out_a_o,
  output logic                        probe_out_b_o,
  output logic [1:0]                  probe_oe_n_o,
  input  wire logic                   jtag_reserve_i,
  input  wire pbsp_pkg::pbsp_jtag_in_t jtag_i,
  input  wire logic                   user_tdo_i,
  input  wire logic                   user_tdo_oe_n_i,
  output logic                        tdo_o,
  output logic                        tdo_oe_n_o,
  output logic [2:0]                  user_jtag_o,
  output logic                        tap_reset_o
);
  import pbsp_pkg::*;

  localparam int SW = 2 * `PBSP_SEL_W;

  //////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; first stage is read only by the second.
  logic [5:0] s1_q, s2_q, s1_d, s2_d;
  logic       tck_prev_q, tck_prev_d, pclk_prev_q, pclk_prev_d;
  always_comb begin
    s1_d = {mode_i, probe_i.clk, probe_i.din,
            jtag_i.tck, jtag_i.tms, jtag_i.tdi};
    s2_d = s1_q;
    tck_prev_d  = s2_q[2];
    pclk_prev_d = s2_q[4];
  end
  always_ff @(posedge clk_i) begin
    s1_q        <= s1_d;
    s2_q        <= s2_d;
    tck_prev_q  <= tck_prev_d;
    pclk_prev_q <= pclk_prev_d;
  end

  logic mode_s, pclk_s, pdin_s, tck_s, tms_s, tdi_s;
  assign {mode_s, pclk_s, pdin_s, tck_s, tms_s, tdi_s} = s2_q;
  logic tck_rise, tck_fall, pclk_rise;
  assign tck_rise  = tck_s & ~tck_prev_q;
  assign tck_fall  = ~tck_s & tck_prev_q;
  assign pclk_rise = pclk_s & ~pclk_prev_q;

  //////////////////////////////////////////////////////////////////////////
  // Probe selection path.
  logic            probe_en;
  logic [SW-1:0]   sel_sh_q, sel_sh_d, sel_q, sel_d;
  logic            mode_prev_q, mode_prev_d;
  logic            pa_q, pa_d, pb_q, pb_d, so_q, so_d;
  logic [1:0]      oe_q, oe_d;

  assign probe_en = mode_s & ~fuse_secure_i;

  always_comb begin
    sel_sh_d    = sel_sh_q;
    sel_d       = sel_q;
    mode_prev_d = probe_en;
    so_d        = so_q;
    if (probe_en && pclk_rise) begin
      sel_sh_d = {sel_sh_q[SW-2:0], pdin_s};
      so_d     = sel_sh_q[SW-1];
    end
    // Selection is latched when the controller drops mode.
    if (mode_prev_q && !probe_en) begin
      sel_d = sel_sh_q;
    end
    // Route selected nets without touching user logic.
    if (probe_reserve_i && probe_en) begin
      pa_d = nets_i[sel_q[SW-1:`PBSP_SEL_W] % NETS];
      pb_d = nets_i[sel_q[`PBSP_SEL_W-1:0] % NETS];
      oe_d = 2'h0;
    end else if (probe_reserve_i) begin
      pa_d = 1'b0;
      pb_d = 1'b0;
      oe_d = 2'h3;
    end else begin
      pa_d = user_pr_i[0];
      pb_d = user_pr_i[1];
      oe_d = 2'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_sh_q    <= '0;
      sel_q       <= '0;
      mode_prev_q <= 1'b0;
      pa_q        <= 1'b0;
      pb_q        <= 1'b0;
      so_q        <= 1'b0;
      oe_q        <= 2'h3;
    end else begin
      sel_sh_q    <= sel_sh_d;
      sel_q       <= sel_d;
      mode_prev_q <= mode_prev_d;
      pa_q        <= pa_d;
      pb_q        <= pb_d;
      so_q        <= so_d;
      oe_q        <= oe_d;
    end
  end
  assign probe_out_a_o      = pa_q;
  assign probe_out_b_o      = pb_q;
  assign probe_oe_n_o       = oe_q;
  assign probe_serial_out_o = so_q;

  //////////////////////////////////////////////////////////////////////////
  // Test access port controller.
  pbsp_tap_t               st_q, st_d;
  logic [`PBSP_IR_W-1:0]   ir_q, ir_d, irsh_q, irsh_d;
  logic [`PBSP_ID_W-1:0]   dr_q, dr_d;
  logic                    tdo_q, tdo_d, toe_q, toe_d;
  logic [2:0]              uj_q, uj_d;

  function automatic pbsp_tap_t tap_next(pbsp_tap_t s, logic m);
    unique case (s)
      TLR:  tap_next = m ? TLR  : RTI;
      RTI:  tap_next = m ? SDRS : RTI;
      SDRS: tap_next = m ? SIRS : CDR;
      CDR:  tap_next = m ? E1DR : SDR;
      SDR:  tap_next = m ? E1DR : SDR;
      E1DR: tap_next = m ? UDR  : PDR;
      PDR:  tap_next = m ? E2DR : PDR;
      E2DR: tap_next = m ? UDR  : SDR;
      UDR:  tap_next = m ? SDRS : RTI;
      SIRS: tap_next = m ? TLR  : CIR;
      CIR:  tap_next = m ? E1IR : SIR;
      SIR:  tap_next = m ? E1IR : SIR;
      E1IR: tap_next = m ? UIR  : PIR;
      PIR:  tap_next = m ? E2IR : PIR;
      E2IR: tap_next = m ? UIR  : SIR;
      UIR:  tap_next = m ? SDRS : RTI;
    endcase
  endfunction : tap_next

  // Unreserved or floating TMS reads as one.
  logic tms_eff, tdi_eff;
  assign tms_eff = jtag_reserve_i ? tms_s : 1'b1;
  assign tdi_eff = tdi_s;

  always_comb begin
    st_d   = st_q;
    ir_d   = ir_q;
    irsh_d = irsh_q;
    dr_d   = dr_q;
    tdo_d  = tdo_q;
    toe_d  = toe_q;
    // Rising test clock: state, shift, decode.
    if (tck_rise) begin
      st_d = tap_next(st_q, tms_eff);
      unique case (st_q)
        CIR:  irsh_d = `PBSP_IR_W'(1);
        SIR:  irsh_d = {tdi_eff, irsh_q[`PBSP_IR_W-1:1]};
        UIR:  ir_d   = irsh_q;
        CDR:  dr_d   = (ir_q == `PBSP_IR_IDCODE) ? `PBSP_ID_DEFAULT : '0;
        SDR:  dr_d   = (ir_q == `PBSP_IR_IDCODE) ?
                       {tdi_eff, dr_q[`PBSP_ID_W-1:1]} :
                       {{(`PBSP_ID_W-1){1'b0}}, tdi_eff};
        TLR:  ir_d   = `PBSP_IR_IDCODE;
        default: ;
      endcase
    end
    if (tck_fall) begin
      toe_d = !(st_q == SDR || st_q == SIR);
      tdo_d = (st_q == SIR) ? irsh_q[0] : dr_q[0];
    end
  end

  always_comb begin
    uj_d = {tck_s, tms_s, tdi_s};
  end

  // Power-on reset forces the reset state.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q   <= TLR;
      ir_q   <= `PBSP_IR_IDCODE;
      irsh_q <= '0;
      dr_q   <= '0;
      tdo_q  <= 1'b0;
      toe_q  <= 1'b1;
      uj_q   <= '0;
    end else begin
      st_q   <= st_d;
      ir_q   <= ir_d;
      irsh_q <= irsh_d;
      dr_q   <= dr_d;
      tdo_q  <= tdo_d;
      toe_q  <= toe_d;
      uj_q   <= uj_d;
    end
  end

  logic to_q, tooe_q, tr_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      to_q   <= 1'b0;
      tooe_q <= 1'b1;
      tr_q   <= 1'b1;
    end else begin
      to_q   <= jtag_reserve_i ? tdo_d : user_tdo_i;
      tooe_q <= jtag_reserve_i ? toe_d : user_tdo_oe_n_i;
      tr_q   <= (st_d == TLR);
    end
  end
  assign tdo_o       = to_q;
  assign tdo_oe_n_o  = tooe_q;
  assign user_jtag_o = uj_q;
  assign tap_reset_o = tr_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [2:0] hi_cnt_q;
  always_ff @(posedge clk_i) begin
    if (srst_i || !tms_eff) hi_cnt_q <= '0;
    else if (tck_rise && hi_cnt_q != 3'h7) hi_cnt_q <= hi_cnt_q + 3'h1;
  end

  property p_tms_reset;
    @(posedge clk_i) disable iff (srst_i)
      hi_cnt_q >= 3'(`PBSP_TMS_RST_TCKS) |-> st_q == TLR;
  endproperty
  a_tms_reset: assert property (p_tms_reset)
    else $error("TAP not in reset after five TMS-high clocks");

  property p_probe_off;
    @(posedge clk_i) disable iff (srst_i)
      (fuse_secure_i || !mode_s) && probe_reserve_i
      |=> probe_oe_n_o == 2'h3;
  endproperty
  a_probe_off: assert property (p_probe_off)
    else $error("Probe pins driven while probing unavailable");

  property p_shift_only_en;
    @(posedge clk_i) disable iff (srst_i)
      !probe_en |=> $stable(sel_sh_q);
  endproperty
  a_shift_only_en: assert property (p_shift_only_en)
    else $error("Selection shifted with probing disabled");

  property p_route_a;
    @(posedge clk_i) disable iff (srst_i)
      probe_reserve_i && probe_en |=>
        probe_out_a_o == $past(nets_i[sel_q[SW-1:`PBSP_SEL_W] % NETS]);
  endproperty
  a_route_a: assert property (p_route_a)
    else $error("Probe output a not the selected net");

  property p_user_pass;
    @(posedge clk_i) disable iff (srst_i)
      !probe_reserve_i |=> probe_out_b_o == $past(user_pr_i[1]);
  endproperty
  a_user_pass: assert property (p_user_pass)
    else $error("Probe pin b not passing user data");

  property p_tdo_user;
    @(posedge clk_i) disable iff (srst_i)
      !jtag_reserve_i |=> tdo_o == $past(user_tdo_i);
  endproperty
  a_tdo_user: assert property (p_tdo_user)
    else $error("TDO not user output when unreserved");

  property p_tdo_fall;
    @(posedge clk_i) disable iff (srst_i)
      !tck_fall |=> $stable(tdo_q);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("TDO changed away from falling test clock");

  property p_tdo_float;
    @(posedge clk_i) disable iff (srst_i)
      tck_fall && st_q == RTI |=> toe_q;
  endproperty
  a_tdo_float: assert property (p_tdo_float)
    else $error("TDO driven outside shift states");
endmodule : pbsp_port

//--- testbench/pbsp_tester.sv
/*
  Model of the probe controller and scan tester beside the port.
  Assumes tasks are started at a falling clk edge from one process.
*/
module pbsp_tester (
  output pbsp_pkg::pbsp_probe_in_t probe_o,
  output logic                     mode_o,
  output pbsp_pkg::pbsp_jtag_in_t  jtag_o,
  input  wire logic                tdo_i
);
  timeunit 1ns;
  timeprecision 1ns;
  import pbsp_pkg::*;

  initial begin
    probe_o = '0;
    mode_o  = 1'b0;
    jtag_o  = 3'b010;
  end

  task automatic select(input logic [15:0] sel, input logic end_mode);
    mode_o = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      probe_o.din = sel[i];
      #160 probe_o.clk = 1'b1;
      #160 probe_o.clk = 1'b0;
    end
    probe_o.din = ~sel[0];
    #160 mode_o = 1'b0;
    #160 mode_o = end_mode;
  endtask : select

  // clock parked low, select line released high
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    jtag_o.tms = tms;
    jtag_o.tdi = tdi;
    #160 jtag_o.tck = 1'b1;
    #150 tdo = tdo_i;
    #10 jtag_o.tck = 1'b0;
    jtag_o.tms = 1'b1;
    jtag_o.tdi = ~tdi;
    #80;
  endtask : step
endmodule : pbsp_tester

//--- testbench/probe_and_boundary_scan_port_test.sv
/*
  Self-checking bench of the probe and boundary-scan port.
  Assumes the package, constants header and tester model are compiled.
*/
`include "pbsp_consts.svh"
module probe_and_boundary_scan_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pbsp_pkg::*;

  logic clk_i = 1'b0, srst_i = 1'b1, fuse_i = 1'b0, pres_i = 1'b1;
  logic jres_i = 1'b1, utdo_i = 1'b0, utdo_oe_n_i = 1'b1;
  logic [1:0] upr_i = 2'b00;
  logic [255:0] nets_i = '0;
  logic mode, pso, pa, pb, tdo, tdo_oe_n, tap_rst;
  logic [1:0] oe_n;
  logic [2:0] ujtag;
  pbsp_probe_in_t probe;
  pbsp_jtag_in_t  jtag;
  int err_count = 0, comparisons = 0, cycles = 0;

  pbsp_port i_pbsp_port (.clk_i(clk_i), .srst_i(srst_i), .mode_i(mode),
    .probe_i(probe), .probe_serial_out_o(pso), .fuse_secure_i(fuse_i),
    .probe_reserve_i(pres_i), .nets_i(nets_i), .user_pr_i(upr_i),
    .probe_out_a_o(pa), .probe_out_b_o(pb), .probe_oe_n_o(oe_n),
    .jtag_reserve_i(jres_i), .jtag_i(jtag), .user_tdo_i(utdo_i),
    .user_tdo_oe_n_i(utdo_oe_n_i), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
    .user_jtag_o(ujtag), .tap_reset_o(tap_rst));
  pbsp_tester i_pbsp_tester (.probe_o(probe), .mode_o(mode),
    .jtag_o(jtag), .tdo_i(tdo));

  always #20 clk_i = ~clk_i;

  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // The whole run needs well under 3000 cycles.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic to_sdr;
    logic b;
    i_pbsp_tester.step(1'b0, 1'b0, b);
    i_pbsp_tester.step(1'b1, 1'b0, b);
    i_pbsp_tester.step(1'b0, 1'b0, b);
    i_pbsp_tester.step(1'b0, 1'b0, b);
  endtask : to_sdr

  task automatic t_reset;
    check("probe_oe_n", oe_n, 2'b11);
    check("tdo_oe_n", tdo_oe_n, 1'b1);
    check("tap_reset", tap_rst, 1'b1);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_tap5;
    logic b;
    to_sdr();
    check("tap_left", tap_rst, 1'b0);
    repeat (4) i_pbsp_tester.step(1'b1, 1'b0, b);
    check("tap_after_4", tap_rst, 1'b0);
    i_pbsp_tester.step(1'b1, 1'b0, b);
    check("tap_after_5", tap_rst, 1'b1);
    $display("t_tap5 done");
  endtask : t_tap5

  task automatic t_idcode;
    logic [31:0] id;
    logic b;
    to_sdr();
    for (int i = 0; i < 32; i++) begin
      // The enable is looked at while the shift state still stands.
      if (i == 31) begin
        check("tdo_oe_n_shift", tdo_oe_n, 1'b0);
      end
      i_pbsp_tester.step(i == 31, 1'b1, b);
      id[i] = b;
    end
    check("idcode", id, `PBSP_ID_DEFAULT);
    repeat (5) i_pbsp_tester.step(1'b1, 1'b0, b);
    check("tdo_oe_n_exit", tdo_oe_n, 1'b1);
    $display("t_idcode done");
  endtask : t_idcode

  task automatic t_user;
    logic b;
    jres_i = 1'b0;
    utdo_i = 1'b1;
    utdo_oe_n_i = 1'b0;
    i_pbsp_tester.step(1'b0, 1'b0, b);
    // Parked pin levels need the synchroniser and output register.
    repeat (4) @(negedge clk_i);
    check("user_jtag", ujtag, 3'b011);
    check("tap_held", tap_rst, 1'b1);
    check("user_tdo", {tdo, tdo_oe_n}, 2'b10);
    jres_i = 1'b1;
    $display("t_user done");
  endtask : t_user

  task automatic t_probe;
    nets_i[8'h12] = 1'b1;
    i_pbsp_tester.select(16'h1235, 1'b1);
    repeat (4) @(negedge clk_i);
    check("probe_ab", {pa, pb, oe_n}, 4'b1000);
    fuse_i = 1'b1;
    i_pbsp_tester.select(16'h3412, 1'b1);
    fuse_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check("fuse_ignored", {pa, pb}, 2'b10);
    i_pbsp_tester.select(16'h3412, 1'b1);
    repeat (4) @(negedge clk_i);
    check("probe_swap", {pa, pb}, 2'b01);
    check("pso_old_lsb", pso, 1'b1);
    pres_i = 1'b0;
    upr_i = 2'b01;
    repeat (4) @(negedge clk_i);
    check("user_pr", {pb, pa}, 2'b01);
    $display("t_probe done");
  endtask : t_probe

  initial begin
    repeat (16) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    t_reset();
    t_tap5();
    t_idcode();
    t_user();
    t_probe();
    tally_and_finish();
  end
endmodule : probe_and_boundary_scan_port_test
